// file: rtl/qcp_params.svh
/*
 Constants of the quad configuration PLL select block: field widths, serial
 register offsets, target address, factory presets and reference divider.
 Assumes inclusion by bare name from files under rtl/.
*/
`ifndef QCP_PARAMS_SVH
`define QCP_PARAMS_SVH

// ----------------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------------
`define QCP_PRE_W 2
`define QCP_POST_W 7
`define QCP_INT_W 7
`define QCP_FRAC_W 18
`define QCP_NUM_SETS 4

// ----------------------------------------------------------------------
// Serial register offsets: byte address = {set[1:0], field[2:0]}
// ----------------------------------------------------------------------
`define QCP_OFS_PRE 3'h0
`define QCP_OFS_POST 3'h1
`define QCP_OFS_INT 3'h2
`define QCP_OFS_FRAC_HI 3'h3
`define QCP_OFS_FRAC_MID 3'h4
`define QCP_OFS_FRAC_LO 3'h5

// Arbitrary serial target address
`define QCP_DEV_ADDR 7'h5a

// ----------------------------------------------------------------------
// Factory presets loaded at power-up
// ----------------------------------------------------------------------
`define QCP_PRE_0 2'h1
`define QCP_PRE_1 2'h1
`define QCP_PRE_2 2'h1
`define QCP_PRE_3 2'h2
`define QCP_POST_0 7'h04
`define QCP_POST_1 7'h06
`define QCP_POST_2 7'h08
`define QCP_POST_3 7'h02
`define QCP_INT_0 7'h19
`define QCP_INT_1 7'h1e
`define QCP_INT_2 7'h1b
`define QCP_INT_3 7'h1a
`define QCP_FRAC_0 18'h00000
`define QCP_FRAC_1 18'h10000
`define QCP_FRAC_2 18'h20000
`define QCP_FRAC_3 18'h08000

// Modulator update rate: one step every this many system clocks
`define QCP_REF_DIV 1

`endif

// file: rtl/qcp_pkg.sv
/*
 Types of the quad configuration PLL select block.
 Assumes nothing of its surroundings.
*/
package qcp_pkg;

   // Serial target states
   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_ADDR     = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_RX       = 4'b0011,
      ST_RX_ACK   = 4'b0100,
      ST_ACK_HOLD = 4'b0101,
      ST_TX       = 4'b0110,
      ST_TX_ACK   = 4'b0111,
      ST_TX_NEXT  = 4'b1000
   } qcp_ser_st_t;

endpackage

// file: rtl/qcp_ser_target.sv
/*
 Two-wire serial target: byte-addressed register writes and reads with
 auto-increment pointer, every byte received after a matching address acknowledged.
 Assumes pin inputs asynchronous to clk; sda is open drain, driven low while
 sda_oe is high. rd_data is combinational from reg_addr.
*/
`timescale 1ns/100ps
`default_nettype none
`include "qcp_params.svh"

module qcp_ser_target #(
   parameter logic [6:0] DEV_ADDR = `QCP_DEV_ADDR
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [7:0] rd_data,
   output logic sda_oe,
   output logic [7:0] reg_addr,
   output logic wr_en,
   output logic [7:0] wr_data,
   output logic busy
);
   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   // ----------------------------------------------------------------------
   // Byte engine
   // ----------------------------------------------------------------------
   qcp_pkg::qcp_ser_st_t st_q, st_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wdat_q, wdat_d, sh_nxt;
   logic [2:0] cnt_q, cnt_d;
   logic oe_q, oe_d, rw_q, rw_d, first_q, first_d, inc_q, inc_d, wr_q, wr_d;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      wdat_d = wdat_q;
      cnt_d = cnt_q;
      oe_d = oe_q;
      rw_d = rw_q;
      first_d = first_q;
      inc_d = inc_q;
      wr_d = 1'b0;
      sh_nxt = {sh_q[6:0], sda_s_q};
      if (start_det) begin
         st_d = qcp_pkg::ST_ADDR;
         cnt_d = 3'h0;
         oe_d = 1'b0;
      end else if (stop_det) begin
         st_d = qcp_pkg::ST_IDLE;
         oe_d = 1'b0;
      end else begin
         unique case (st_q)
            qcp_pkg::ST_IDLE: begin
            end
            qcp_pkg::ST_ADDR: if (scl_rise) begin
               sh_d = sh_nxt;
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == 3'h7) st_d = qcp_pkg::ST_ADDR_ACK;
            end
            qcp_pkg::ST_ADDR_ACK: if (scl_fall) begin
               if (sh_q[7:1] == DEV_ADDR) begin
                  oe_d = 1'b1;
                  rw_d = sh_q[0];
                  first_d = 1'b1;
                  st_d = qcp_pkg::ST_ACK_HOLD;
               end else begin
                  st_d = qcp_pkg::ST_IDLE;
               end
            end
            qcp_pkg::ST_RX: if (scl_rise) begin
               sh_d = sh_nxt;
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  st_d = qcp_pkg::ST_RX_ACK;
                  if (first_q) begin
                     ptr_d = sh_nxt;
                     first_d = 1'b0;
                  end else begin
                     wr_d = 1'b1;
                     wdat_d = sh_nxt;
                     inc_d = 1'b1;
                  end
               end
            end
            qcp_pkg::ST_RX_ACK: if (scl_fall) begin
               oe_d = 1'b1;
               st_d = qcp_pkg::ST_ACK_HOLD;
               if (inc_q) ptr_d = ptr_q + 8'h01;
               inc_d = 1'b0;
            end
            qcp_pkg::ST_ACK_HOLD: if (scl_fall) begin
               cnt_d = 3'h0;
               if (rw_q) begin
                  sh_d = rd_data;
                  oe_d = ~rd_data[7];
                  st_d = qcp_pkg::ST_TX;
               end else begin
                  oe_d = 1'b0;
                  st_d = qcp_pkg::ST_RX;
               end
            end
            qcp_pkg::ST_TX: if (scl_fall) begin
               if (cnt_q == 3'h7) begin
                  oe_d = 1'b0;
                  st_d = qcp_pkg::ST_TX_ACK;
               end else begin
                  cnt_d = cnt_q + 3'h1;
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_q[6];
               end
            end
            qcp_pkg::ST_TX_ACK: if (scl_rise) begin
               if (sda_s_q) begin
                  st_d = qcp_pkg::ST_IDLE;
               end else begin
                  ptr_d = ptr_q + 8'h01;
                  st_d = qcp_pkg::ST_TX_NEXT;
               end
            end
            qcp_pkg::ST_TX_NEXT: if (scl_fall) begin
               sh_d = rd_data;
               oe_d = ~rd_data[7];
               cnt_d = 3'h0;
               st_d = qcp_pkg::ST_TX;
            end
            default: st_d = qcp_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= qcp_pkg::ST_IDLE;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         wdat_q <= 8'h00;
         cnt_q <= 3'h0;
         oe_q <= 1'b0;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         inc_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         wdat_q <= wdat_d;
         cnt_q <= cnt_d;
         oe_q <= oe_d;
         rw_q <= rw_d;
         first_q <= first_d;
         inc_q <= inc_d;
         wr_q <= wr_d;
      end
   end

   assign sda_oe = oe_q;
   assign reg_addr = ptr_q;
   assign wr_en = wr_q;
   assign wr_data = wdat_q;
   assign busy = (st_q != qcp_pkg::ST_IDLE);

endmodule
`default_nettype wire

// file: rtl/qcp_top.sv
/*
 Quad configuration PLL select: four divider sets with factory presets,
 serial reprogramming and readback, pin selection of the active set,
 fractional feedback modulator and asynchronous output enable.
 Assumes CLK_SYS at 100 MHz serves as the crystal reference domain, SYS_RST
 stands for power-up, and the analog PLL and LVDS drivers sit outside.
*/
// Notes on behaviour
// - Output enable low tri-states both clock outputs; high or open enables them.
// - Output enable acts at once, with no clock edge in between.
// - Four independent divider sets, each with pre, int, frac and post fields.
// - Two select pins, high bit first, pick set 0 to 3 directly.
// - Select pins default low, so open pins pick set 0.
// - Power-up loads factory presets into all four sets; writes are volatile.
// - A select change switches the dividers three system clocks later, no further command.
// - Serial host may write any set and read back all four.
// - Pre-divider field is 2 bits, post divider field 7 bits.
// - Feedback divider has a 7-bit integer and 18-bit fraction.
// - Output is ref over pre times post, times int plus (frac+0.5)/2^18.
// - Reference comes from an internal crystal of 114.285 or 100 MHz.
// - Fractional feedback is realised by a delta-sigma modulator dithering the ratio.
`timescale 1ns/100ps
`default_nettype none
`include "qcp_params.svh"

module qcp_top #(
   parameter logic [6:0] DEV_ADDR = `QCP_DEV_ADDR,
   parameter int REF_DIV = `QCP_REF_DIV
) (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic OUT_EN,
   input wire logic FREQ_SEL_HI,
   input wire logic FREQ_SEL_LO,
   input wire logic SER_CLK_PIN,
   input wire logic SER_DATA_PIN_I,
   output logic SER_DATA_PIN_O,
   output logic SER_DATA_PIN_OE,
   output logic CLK_OUT_OE,
   output logic [1:0] ACTIVE_SET,
   output logic [`QCP_PRE_W-1:0] PLL_PRE_DIV,
   output logic [`QCP_POST_W-1:0] PLL_POST_DIV,
   output logic [`QCP_INT_W-1:0] PLL_FB_INT,
   output logic [`QCP_FRAC_W-1:0] PLL_FB_FRAC,
   output logic [`QCP_INT_W:0] PLL_FB_DIV_NOW,
   output logic REF_STEP,
   output logic WRITE_TO_ACTIVE,
   output logic SER_BUSY
);
   localparam int PW = `QCP_PRE_W;
   localparam int NW = `QCP_POST_W;
   localparam int IW = `QCP_INT_W;
   localparam int FW = `QCP_FRAC_W;
   localparam int NS = `QCP_NUM_SETS;

   // ----------------------------------------------------------------------
   // Output enable
   // ----------------------------------------------------------------------
   // Straight from the pin so the drivers react without a clock edge;
   // the open pin reads high through the pad pull-up.
   assign CLK_OUT_OE = OUT_EN;

   // ----------------------------------------------------------------------
   // Select pin synchronisers
   // ----------------------------------------------------------------------
   logic [1:0] sel_m_q, sel_s_q;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         sel_m_q <= 2'h0;
         sel_s_q <= 2'h0;
      end else begin
         sel_m_q <= {FREQ_SEL_HI, FREQ_SEL_LO};
         sel_s_q <= sel_m_q;
      end
   end

   // ----------------------------------------------------------------------
   // Serial target
   // ----------------------------------------------------------------------
   logic [7:0] reg_addr, wr_data, rd_data;
   logic wr_en, ser_oe, ser_busy;

   qcp_ser_target #(
      .DEV_ADDR(DEV_ADDR)
   ) u_ser (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .scl_i(SER_CLK_PIN),
      .sda_i(SER_DATA_PIN_I),
      .rd_data(rd_data),
      .sda_oe(ser_oe),
      .reg_addr(reg_addr),
      .wr_en(wr_en),
      .wr_data(wr_data),
      .busy(ser_busy)
   );

   // ----------------------------------------------------------------------
   // Configuration sets
   // ----------------------------------------------------------------------
   localparam logic [PW-1:0] PRE_INIT [NS] = '{`QCP_PRE_0, `QCP_PRE_1, `QCP_PRE_2, `QCP_PRE_3};
   localparam logic [NW-1:0] POST_INIT [NS] =
      '{`QCP_POST_0, `QCP_POST_1, `QCP_POST_2, `QCP_POST_3};
   localparam logic [IW-1:0] INT_INIT [NS] = '{`QCP_INT_0, `QCP_INT_1, `QCP_INT_2, `QCP_INT_3};
   localparam logic [FW-1:0] FRAC_INIT [NS] =
      '{`QCP_FRAC_0, `QCP_FRAC_1, `QCP_FRAC_2, `QCP_FRAC_3};

   logic [PW-1:0] pre_q [NS];
   logic [PW-1:0] pre_d [NS];
   logic [NW-1:0] post_q [NS];
   logic [NW-1:0] post_d [NS];
   logic [IW-1:0] int_q [NS];
   logic [IW-1:0] int_d [NS];
   logic [FW-1:0] frac_q [NS];
   logic [FW-1:0] frac_d [NS];
   logic [1:0] wset;
   logic [2:0] wfld;
   logic in_map;

   assign wset = reg_addr[4:3];
   assign wfld = reg_addr[2:0];
   assign in_map = (reg_addr[7:5] == 3'h0);

   always_comb begin
      pre_d = pre_q;
      post_d = post_q;
      int_d = int_q;
      frac_d = frac_q;
      if (wr_en && in_map) begin
         unique case (wfld)
            `QCP_OFS_PRE: pre_d[wset] = wr_data[PW-1:0];
            `QCP_OFS_POST: post_d[wset] = wr_data[NW-1:0];
            `QCP_OFS_INT: int_d[wset] = wr_data[IW-1:0];
            `QCP_OFS_FRAC_HI: frac_d[wset][17:16] = wr_data[1:0];
            `QCP_OFS_FRAC_MID: frac_d[wset][15:8] = wr_data;
            `QCP_OFS_FRAC_LO: frac_d[wset][7:0] = wr_data;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         pre_q <= PRE_INIT;
         post_q <= POST_INIT;
         int_q <= INT_INIT;
         frac_q <= FRAC_INIT;
      end else begin
         pre_q <= pre_d;
         post_q <= post_d;
         int_q <= int_d;
         frac_q <= frac_d;
      end
   end

   // Readback of all four sets; unused offsets read zero
   always_comb begin
      rd_data = 8'h00;
      if (in_map) begin
         unique case (wfld)
            `QCP_OFS_PRE: rd_data = {6'h00, pre_q[wset]};
            `QCP_OFS_POST: rd_data = {1'b0, post_q[wset]};
            `QCP_OFS_INT: rd_data = {1'b0, int_q[wset]};
            `QCP_OFS_FRAC_HI: rd_data = {6'h00, frac_q[wset][17:16]};
            `QCP_OFS_FRAC_MID: rd_data = frac_q[wset][15:8];
            `QCP_OFS_FRAC_LO: rd_data = frac_q[wset][7:0];
            default: rd_data = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Active divider outputs
   // ----------------------------------------------------------------------
   logic [1:0] act_q, act_d;
   logic [PW-1:0] apre_q, apre_d;
   logic [NW-1:0] apost_q, apost_d;
   logic [IW-1:0] aint_q, aint_d;
   logic [FW-1:0] afrac_q, afrac_d;
   logic wact_q, wact_d, sda_o_q, sda_oe_q, busy_q;

   always_comb begin
      act_d = sel_s_q;
      apre_d = pre_q[sel_s_q];
      apost_d = post_q[sel_s_q];
      aint_d = int_q[sel_s_q];
      afrac_d = frac_q[sel_s_q];
      // Flags a write landing in the set that is driving the PLL
      wact_d = wr_en && in_map && (wset == sel_s_q);
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         act_q <= 2'h0;
         apre_q <= PRE_INIT[0];
         apost_q <= POST_INIT[0];
         aint_q <= INT_INIT[0];
         afrac_q <= FRAC_INIT[0];
         wact_q <= 1'b0;
         sda_o_q <= 1'b0;
         sda_oe_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         act_q <= act_d;
         apre_q <= apre_d;
         apost_q <= apost_d;
         aint_q <= aint_d;
         afrac_q <= afrac_d;
         wact_q <= wact_d;
         sda_o_q <= 1'b0;
         sda_oe_q <= ser_oe;
         busy_q <= ser_busy;
      end
   end

   // ----------------------------------------------------------------------
   // Reference step divider and feedback modulator
   // ----------------------------------------------------------------------
   // First-order accumulator over 2^19 adding 2*frac+1, so the average ratio
   // is int + (frac + 0.5) / 2^18 exactly.
   logic [15:0] rcnt_q, rcnt_d;
   logic step_q, step_d;
   logic [FW:0] acc_q, acc_d;
   logic [FW+1:0] acc_sum;
   logic [IW:0] fbd_q, fbd_d;

   always_comb begin
      rcnt_d = rcnt_q + 16'h0001;
      step_d = 1'b0;
      if (rcnt_q >= 16'(REF_DIV - 1)) begin
         rcnt_d = 16'h0000;
         step_d = 1'b1;
      end
      acc_sum = {1'b0, acc_q} + {1'b0, afrac_q, 1'b1};
      acc_d = acc_q;
      fbd_d = fbd_q;
      if (step_q) begin
         acc_d = acc_sum[FW:0];
         fbd_d = {1'b0, aint_q} + {{IW{1'b0}}, acc_sum[FW+1]};
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         rcnt_q <= 16'h0000;
         step_q <= 1'b0;
         acc_q <= '0;
         fbd_q <= {1'b0, INT_INIT[0]};
      end else begin
         rcnt_q <= rcnt_d;
         step_q <= step_d;
         acc_q <= acc_d;
         fbd_q <= fbd_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign ACTIVE_SET = act_q;
   assign PLL_PRE_DIV = apre_q;
   assign PLL_POST_DIV = apost_q;
   assign PLL_FB_INT = aint_q;
   assign PLL_FB_FRAC = afrac_q;
   assign PLL_FB_DIV_NOW = fbd_q;
   assign REF_STEP = step_q;
   assign WRITE_TO_ACTIVE = wact_q;
   assign SER_DATA_PIN_O = sda_o_q;
   assign SER_DATA_PIN_OE = sda_oe_q;
   assign SER_BUSY = busy_q;

endmodule
`default_nettype wire

// file: bench/qcp_checker.sv
/*
 Port assertions of the quad configuration PLL select top.
 Assumes binding into qcp_top; one clock domain, reset synchronous high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "qcp_params.svh"
module qcp_checker (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic OUT_EN,
   input wire logic FREQ_SEL_HI,
   input wire logic FREQ_SEL_LO,
   input wire logic SER_CLK_PIN,
   input wire logic SER_DATA_PIN_I,
   input wire logic SER_DATA_PIN_O,
   input wire logic SER_DATA_PIN_OE,
   input wire logic CLK_OUT_OE,
   input wire logic [1:0] ACTIVE_SET,
   input wire logic [`QCP_PRE_W-1:0] PLL_PRE_DIV,
   input wire logic [`QCP_POST_W-1:0] PLL_POST_DIV,
   input wire logic [`QCP_INT_W-1:0] PLL_FB_INT,
   input wire logic [`QCP_FRAC_W-1:0] PLL_FB_FRAC,
   input wire logic [`QCP_INT_W:0] PLL_FB_DIV_NOW,
   input wire logic REF_STEP,
   input wire logic WRITE_TO_ACTIVE,
   input wire logic SER_BUSY
);
   wire logic [1:0] sel = {FREQ_SEL_HI, FREQ_SEL_LO};
   wire logic [33:0] fields = {PLL_PRE_DIV, PLL_POST_DIV, PLL_FB_INT, PLL_FB_FRAC};
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   // -----------------------------------------------------------
   // Relations between ports
   // -----------------------------------------------------------
   sequence sel_settled;
      $stable(sel) [*6];
   endsequence
   AST_OE_LEVEL: assert property (CLK_OUT_OE == OUT_EN)
      else $error("clock output enable differs from pin");
   AST_OE_ASYNC: assert property (@(negedge CLK_SYS) CLK_OUT_OE == OUT_EN)
      else $error("clock output enable lags pin");
   AST_SEL_MAP: assert property (sel_settled |-> ACTIVE_SET == sel)
      else $error("active set differs from settled select pins");
   AST_FIELD_CAUSE: assert property ($changed(fields) |->
      $changed(ACTIVE_SET) || $past(WRITE_TO_ACTIVE))
      else $error("divider fields changed without cause");
   AST_RESET_PRESET: assert property (disable iff (1'b0) SYS_RST |=>
      ACTIVE_SET == 2'h0 && PLL_PRE_DIV == `QCP_PRE_0 && PLL_POST_DIV == `QCP_POST_0
      && PLL_FB_INT == `QCP_INT_0 && PLL_FB_FRAC == `QCP_FRAC_0 && !SER_BUSY)
      else $error("reset state differs from set 0 presets");
   AST_MOD_RATIO: assert property (REF_STEP ##0 $stable(PLL_FB_INT) [*3] |->
      PLL_FB_DIV_NOW - {1'b0, PLL_FB_INT} <= 8'h01)
      else $error("dithered ratio outside integer and integer plus one");
   AST_DATA_LOW: assert property (SER_DATA_PIN_O == 1'b0)
      else $error("data pin output value not low");
   AST_OE_FRAME: assert property (SER_DATA_PIN_OE |-> SER_BUSY || $past(SER_BUSY))
      else $error("data pin driven outside a transfer");
   AST_OE_EDGE: assert property ($changed(SER_DATA_PIN_OE) |-> !SER_CLK_PIN)
      else $error("data pin drive changed while serial clock high");
   AST_WTA_BUSY: assert property (WRITE_TO_ACTIVE |-> SER_BUSY)
      else $error("active set write flag outside a transfer");
endmodule
bind qcp_top qcp_checker u_qcp_checker (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
   .OUT_EN(OUT_EN), .FREQ_SEL_HI(FREQ_SEL_HI), .FREQ_SEL_LO(FREQ_SEL_LO),
   .SER_CLK_PIN(SER_CLK_PIN), .SER_DATA_PIN_I(SER_DATA_PIN_I),
   .SER_DATA_PIN_O(SER_DATA_PIN_O), .SER_DATA_PIN_OE(SER_DATA_PIN_OE),
   .CLK_OUT_OE(CLK_OUT_OE), .ACTIVE_SET(ACTIVE_SET), .PLL_PRE_DIV(PLL_PRE_DIV),
   .PLL_POST_DIV(PLL_POST_DIV), .PLL_FB_INT(PLL_FB_INT), .PLL_FB_FRAC(PLL_FB_FRAC),
   .PLL_FB_DIV_NOW(PLL_FB_DIV_NOW), .REF_STEP(REF_STEP),
   .WRITE_TO_ACTIVE(WRITE_TO_ACTIVE), .SER_BUSY(SER_BUSY));
`default_nettype wire

// file: bench/qcp_host_model.sv
/*
 Serial host model: start, stop and byte transfers, 160 ns bit period.
 Assumes the bench resolves the pulled-up data wire from all drivers.
*/
`timescale 1ns/100ps
`default_nettype none
module qcp_host_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_oe
);
   // -----------------------------------------------------------
   // Serial clock idles high between frames
   // -----------------------------------------------------------
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic dat(input logic d);
      sda_oe = !d;
      repeat (4) @(negedge clk);
   endtask
   task automatic clk_to(input logic c);
      scl = c;
      repeat (c ? 8 : 4) @(negedge clk);
   endtask
   task automatic start();
      dat(1'b1);
      clk_to(1'b1);
      dat(1'b0);
      clk_to(1'b0);
   endtask
   task automatic xfer(input logic b, output logic r);
      dat(b);
      clk_to(1'b1);
      r = sda;
      clk_to(1'b0);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(b[i], r);
      end
      xfer(1'b1, r);
      ack = !r;
   endtask
   task automatic recv(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, r);
         b = {b[6:0], r};
      end
      xfer(last, r);
   endtask
   task automatic stop();
      dat(1'b0);
      clk_to(1'b1);
      dat(1'b1);
   endtask
endmodule
`default_nettype wire

// file: bench/tb_quad_config_pll_select.sv
/*
 Bench of the quad configuration PLL select top: pins, presets, serial
 write and readback, modulator average and preset restore on reset.
 Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "qcp_params.svh"
module tb_quad_config_pll_select;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic out_en = 1'b1;
   logic [1:0] sel = 2'h0;
   logic scl, host_oe, sda, dev_o, dev_oe, clk_oe, step, wta, busy, ack;
   logic wta_seen = 1'b0;
   logic [1:0] act, pre;
   logic [6:0] post, fbi;
   logic [17:0] frac;
   logic [7:0] div_now;
   logic [7:0] wq [$];
   logic [1:0] pre_e [4];
   logic [6:0] post_e [4], int_e [4];
   logic [17:0] frac_e [4];
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   int ones;
   always #5 clk = ~clk;
   assign sda = host_oe ? 1'b0 : (dev_oe ? dev_o : 1'b1);
   qcp_top #(.DEV_ADDR(`QCP_DEV_ADDR), .REF_DIV(1)) u_qcp_top (.CLK_SYS(clk),
      .SYS_RST(rst), .OUT_EN(out_en), .FREQ_SEL_HI(sel[1]), .FREQ_SEL_LO(sel[0]),
      .SER_CLK_PIN(scl), .SER_DATA_PIN_I(sda), .SER_DATA_PIN_O(dev_o),
      .SER_DATA_PIN_OE(dev_oe), .CLK_OUT_OE(clk_oe), .ACTIVE_SET(act),
      .PLL_PRE_DIV(pre), .PLL_POST_DIV(post), .PLL_FB_INT(fbi), .PLL_FB_FRAC(frac),
      .PLL_FB_DIV_NOW(div_now), .REF_STEP(step), .WRITE_TO_ACTIVE(wta), .SER_BUSY(busy));
   qcp_host_model u_qcp_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
   // -----------------------------------------------------------
   // Checking and access tasks
   // -----------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic load_presets();
      pre_e = '{`QCP_PRE_0, `QCP_PRE_1, `QCP_PRE_2, `QCP_PRE_3};
      post_e = '{`QCP_POST_0, `QCP_POST_1, `QCP_POST_2, `QCP_POST_3};
      int_e = '{`QCP_INT_0, `QCP_INT_1, `QCP_INT_2, `QCP_INT_3};
      frac_e = '{`QCP_FRAC_0, `QCP_FRAC_1, `QCP_FRAC_2, `QCP_FRAC_3};
   endtask
   function automatic logic [7:0] exp_byte(input logic [7:0] p);
      if (p[7:5] != 3'h0) return 8'h00;
      case (p[2:0])
         `QCP_OFS_PRE: return {6'h00, pre_e[p[4:3]]};
         `QCP_OFS_POST: return {1'b0, post_e[p[4:3]]};
         `QCP_OFS_INT: return {1'b0, int_e[p[4:3]]};
         `QCP_OFS_FRAC_HI: return {6'h00, frac_e[p[4:3]][17:16]};
         `QCP_OFS_FRAC_MID: return frac_e[p[4:3]][15:8];
         `QCP_OFS_FRAC_LO: return frac_e[p[4:3]][7:0];
         default: return 8'h00;
      endcase
   endfunction
   task automatic head(input logic [7:0] p);
      u_qcp_host_model.start();
      u_qcp_host_model.send({`QCP_DEV_ADDR, 1'b0}, ack);
      chk("addr ack", ack, 1'b1);
      u_qcp_host_model.send(p, ack);
      chk("ptr ack", ack, 1'b1);
   endtask
   task automatic wr(input logic [7:0] p);
      head(p);
      foreach (wq[i]) begin
         u_qcp_host_model.send(wq[i], ack);
         chk("data ack", ack, 1'b1);
      end
      u_qcp_host_model.stop();
   endtask
   task automatic rd(input logic [7:0] p, input int n);
      logic [7:0] b;
      head(p);
      u_qcp_host_model.start();
      u_qcp_host_model.send({`QCP_DEV_ADDR, 1'b1}, ack);
      for (int i = 0; i < n; i++) begin
         u_qcp_host_model.recv(i == n - 1, b);
         chk("read byte", b, exp_byte(p + 8'(i)));
      end
      u_qcp_host_model.stop();
   endtask
   task automatic pick(input logic [1:0] s);
      @(negedge clk);
      sel = s;
      repeat (8) @(negedge clk);
   endtask
   task automatic chk_set(input logic [1:0] s);
      chk("active set", act, s);
      chk("pre div", pre, pre_e[s]);
      chk("post div", post, post_e[s]);
      chk("fb int", fbi, int_e[s]);
      chk("fb frac", frac, frac_e[s]);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      wta_seen <= wta_seen | (wta === 1'b1);
      if (cyc == 40000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // -----------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------
   initial begin
      load_presets();
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk_set(2'h0);
      chk("out enable", clk_oe, 1'b1);
      out_en = 1'b0;
      #1;
      chk("out disable", clk_oe, 1'b0);
      out_en = 1'b1;
      for (int s = 3; s >= 0; s--) begin
         pick(2'(s));
         chk_set(2'(s));
      end
      rd(8'h00, 32);
      wq = '{8'h01, 8'h05, 8'h20, 8'h01, 8'h23, 8'h45};
      wr(8'h10);
      chk("write hit flag", wta_seen, 1'b0);
      chk_set(2'h0);
      pre_e[2] = 2'h1;
      post_e[2] = 7'h05;
      int_e[2] = 7'h20;
      frac_e[2] = 18'h12345;
      pick(2'h2);
      chk_set(2'h2);
      rd(8'h10, 8);
      wq = '{8'h06};
      wr(8'h11);
      post_e[2] = 7'h06;
      repeat (4) @(negedge clk);
      chk("write hit flag", wta_seen, 1'b1);
      chk_set(2'h2);
      u_qcp_host_model.start();
      u_qcp_host_model.send({`QCP_DEV_ADDR ^ 7'h01, 1'b0}, ack);
      chk("foreign ack", ack, 1'b0);
      u_qcp_host_model.stop();
      pick(2'h1);
      ones = 0;
      repeat (1024) begin
         @(negedge clk);
         ones += int'(div_now === {1'b0, int_e[1]} + 8'h01);
      end
      chk("carry count", ones >= 256 && ones <= 257, 1'b1);
      rst = 1'b1;
      pick(2'h2);
      rst = 1'b0;
      load_presets();
      repeat (8) @(negedge clk);
      chk_set(2'h2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
